// ==== area_pkg.sv ====
// Shared constants and types for the area select and speed monitor
`default_nettype none
package area_pkg;
	// ============================================================
	// Timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int MS_NS = 1000000;
	localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
	localparam int GATE_MS = 100;
	localparam int GATES_PER_SEC = 1000 / GATE_MS;
	localparam int MAX_PULSE_HZ = 100000;
	localparam logic [15:0] MAX_GATE_COUNT = 16'(MAX_PULSE_HZ / GATES_PER_SEC);
	localparam logic [15:0] SLOW_CMS = 16'h0009;
	localparam logic [15:0] FAST_CMS = 16'h001E;
	localparam int TOL_SLOW_S = 60;
	localparam int TOL_FAST_S = 20;
	localparam logic [15:0] TOL_SLOW_MS = 16'(TOL_SLOW_S * 1000);
	localparam logic [15:0] TOL_FAST_MS = 16'(TOL_FAST_S * 1000);
	localparam logic [15:0] TOL_DIR_MS = 16'h012C;
	localparam logic [6:0] TOL_MAX_PCT = 7'h50;
	// ============================================================
	// Register offsets
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_ENC = 12'h004;
	localparam logic [11:0] OFF_TOL = 12'h008;
	localparam logic [11:0] OFF_PAT = 12'h00C;
	localparam logic [11:0] OFF_STATUS = 12'h010;
	localparam logic [11:0] OFF_SPEED = 12'h014;
	localparam logic [11:0] OFF_LIMITS = 12'h018;
	localparam logic [4:0] WIN_PAGE = 5'h01;
	localparam logic [4:0] RANGE_PAGE = 5'h01;
	// Field positions
	localparam int CTRL_ENC_BIT = 4;
	localparam int STAT_FAULT_LSB = 8;
	localparam int STAT_SAFE_BIT = 16;
	localparam int STAT_PAIR_BIT = 17;
	// Reset values
	localparam logic [2:0] PAIRS_RST = 3'h4;
	localparam logic [15:0] PPC_RST = 16'h0040;
	localparam logic [6:0] TOL_PCT_RST = 7'h0A;
	localparam logic [15:0] DELAY_MS_RST = 16'h001E;
	localparam logic [7:0] KINDS_RST = 8'h02;
	// ============================================================
	// Types
	typedef enum logic [1:0] {PAT_UNUSED = 2'h0, PAT_STATIC = 2'h1,
		PAT_ENCODER = 2'h2} pattern_kind_type;
	typedef enum logic {ST_STABLE = 1'b0, ST_SETTLE = 1'b1} settle_state_type;
	typedef struct packed {
		logic valid;
		logic [1:0] pattern;
		logic [4:0] area;
		logic signed [15:0] upper;
	} range_entry_type;
	typedef struct packed {
		logic signed [15:0] hi;
		logic signed [15:0] lo;
	} window_type;
	typedef struct packed {
		logic range_miss;
		logic window;
		logic direction;
		logic tolerance;
		logic pair;
	} fault_type;
endpackage
`default_nettype wire

// ==== area_select_speed_monitor.sv ====
// Area selection from switch pairs or encoder speed, with encoder monitoring
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1 - Four pairs: area is one plus code
// R2 - Three pairs decode areas one to eight
// R3 - Two pairs decode areas one to four
// R4 - One pair selects area one or two
// R5 - Two encoders processed side by side
// R6 - Phase B high at A rise: forward
// R7 - Phase B low at A rise: backward
// R8 - Speed and direction measured continuously
// R9 - Speed equals pulse rate over pulses-per-cm
// R10 - Min and max speed from pulses-per-cm
// R11 - Tolerance percent settable zero to eighty
// R12 - Larger encoder speed is vehicle speed
// R13 - Mismatch beyond period drops safety output
// R14 - Period: none, sixty or twenty seconds
// R15 - Opposite directions above nine: short trip
// R16 - Encoder mode: four patterns, one encoder
// R17 - Up to thirty-two speed ranges
// R18 - Area follows range holding current speed
// R19 - No area twice within one pattern
// R20 - Static pattern: fixed area, optional window
// R21 - Speed outside window drops safety output
// R22 - Non-complementary pair flags an error
// R23 - Inputs must settle for area delay
// R24 - Drop means safety output goes off
// R25 - Inputs synchronised before decoding
// R26 - Speed from signed edges per gate
module area_select_speed_monitor #(
	parameter int CYC_PER_MS = area_pkg::CYC_PER_MS,
	parameter int PAIRS = 4,
	parameter int RANGES = 32
) (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Selection switch pairs and encoders
	input wire logic [3:0] sel_normal,
	input wire logic [3:0] sel_inverse,
	input wire logic [1:0] enc_phase_a,
	input wire logic [1:0] enc_phase_b,
	// Results
	output logic safety_output,
	output logic [5:0] active_area
);
	localparam int DW = $clog2(CYC_PER_MS + 1);
	localparam int GW = $clog2(area_pkg::GATE_MS + 1);

	if (CYC_PER_MS < 2 || PAIRS != 4 || RANGES != 32) begin : g_check
		$error("Unsupported parameter values");
	end

	// ============================================================
	// Functions
	function automatic logic [15:0] mag_of(input logic signed [15:0] v);
		mag_of = v[15] ? 16'(-v) : 16'(v);
	endfunction

	function automatic logic signed [15:0] speed_of(input logic signed [15:0] cnt,
		input logic [15:0] ppc);
		logic [31:0] q;
		q = (32'(mag_of(cnt)) * 32'(area_pkg::GATES_PER_SEC))
			/ 32'((ppc == 16'h0000) ? 16'h0001 : ppc);
		if (q > 32'h00007FFF) begin
			q = 32'h00007FFF;
		end
		speed_of = cnt[15] ? -$signed(q[15:0]) : $signed(q[15:0]);
	endfunction

	function automatic logic [3:0] mask_of(input logic [2:0] pairs);
		case (pairs)
			3'h1: mask_of = 4'h1;
			3'h2: mask_of = 4'h3;
			3'h3: mask_of = 4'h7;
			default: mask_of = 4'hF;
		endcase
	endfunction

	function automatic logic [2:0] clamp_pairs(input logic [2:0] p);
		clamp_pairs = (p == 3'h0) ? 3'h1 : ((p > 3'h4) ? 3'h4 : p);
	endfunction

	// ============================================================
	// Input synchronisers
	logic [11:0] sync1, sync2, sync3, stab;
	wire [11:0] raw_in = {enc_phase_b, enc_phase_a, sel_inverse, sel_normal};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= 12'h000;
			sync2 <= 12'h000;
			sync3 <= 12'h000;
			stab <= 12'h000;
		end else begin
			sync1 <= raw_in;
			sync2 <= sync1;
			sync3 <= sync2;
			// Only a value seen twice in a row is taken
			stab <= (sync2 ~^ sync3) & sync3 | (sync2 ^ sync3) & stab; // R25
		end
	end
	wire [3:0] sw_n = stab[3:0];
	wire [3:0] sw_i = stab[7:4];
	wire [1:0] enc_a = stab[9:8];
	wire [1:0] enc_b = stab[11:10];

	// ============================================================
	// Millisecond and gate enables
	logic [DW-1:0] div_cnt;
	logic [GW-1:0] gate_cnt;
	logic ms_tick, gate_tick;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= '0;
			gate_cnt <= '0;
			ms_tick <= 1'b0;
			gate_tick <= 1'b0;
		end else begin
			ms_tick <= (div_cnt == DW'(CYC_PER_MS - 1));
			div_cnt <= (div_cnt == DW'(CYC_PER_MS - 1)) ? '0 : div_cnt + 1'b1;
			gate_tick <= ms_tick && (gate_cnt == GW'(area_pkg::GATE_MS - 1));
			if (ms_tick) begin
				gate_cnt <= (gate_cnt == GW'(area_pkg::GATE_MS - 1)) ? '0 : gate_cnt + 1'b1;
			end
		end
	end

	// ============================================================
	// Configuration registers
	logic [2:0] pairs_cfg;
	logic enc_mode;
	logic [15:0] ppc [2];
	logic [6:0] tol_pct;
	logic [15:0] area_delay;
	logic [7:0] kinds;
	logic [19:0] statics;
	logic [3:0] mon_en;
	area_pkg::window_type win [4];
	area_pkg::range_entry_type ranges [RANGES];
	area_pkg::fault_type faults;

	wire acc = psel && penable;
	wire wr_fire = acc && pready && pwrite;
	wire hit_win = (paddr[11:7] == 5'h00) && (paddr[6:4] == 3'(area_pkg::WIN_PAGE << 2));
	wire hit_range = (paddr[11:7] == area_pkg::RANGE_PAGE);
	wire [1:0] win_idx = paddr[3:2];
	wire [4:0] range_idx = paddr[6:2];
	wire [6:0] tol_in = (pwdata[6:0] > area_pkg::TOL_MAX_PCT) ? area_pkg::TOL_MAX_PCT : pwdata[6:0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pairs_cfg <= area_pkg::PAIRS_RST;
			enc_mode <= 1'b0;
			ppc[0] <= area_pkg::PPC_RST;
			ppc[1] <= area_pkg::PPC_RST;
			tol_pct <= area_pkg::TOL_PCT_RST;
			area_delay <= area_pkg::DELAY_MS_RST;
			kinds <= area_pkg::KINDS_RST;
			statics <= 20'h00000;
			mon_en <= 4'h0;
			win <= '{default: '0};
			ranges <= '{default: '0};
		end else if (wr_fire) begin
			if (paddr == area_pkg::OFF_CTRL) begin
				pairs_cfg <= clamp_pairs(pwdata[2:0]);
				enc_mode <= pwdata[area_pkg::CTRL_ENC_BIT];
			end
			if (paddr == area_pkg::OFF_ENC) begin
				ppc[0] <= pwdata[15:0]; // R9
				ppc[1] <= pwdata[31:16];
			end
			if (paddr == area_pkg::OFF_TOL) begin
				tol_pct <= tol_in; // R11
				area_delay <= pwdata[31:16];
			end
			if (paddr == area_pkg::OFF_PAT) begin
				kinds <= pwdata[7:0];
				statics <= pwdata[27:8];
				mon_en <= pwdata[31:28];
			end
			if (hit_win) begin
				win[win_idx] <= pwdata;
			end
			if (hit_range) begin
				ranges[range_idx] <= pwdata[23:0];
			end
		end
	end

	// ============================================================
	// Encoder measurement
	logic [1:0] a_prev, fwd;
	logic signed [15:0] cnt [2];
	logic signed [15:0] spd [2];
	wire [1:0] a_rise = enc_a & ~a_prev;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_prev <= 2'h0;
			fwd <= 2'h0;
			cnt <= '{default: '0};
			spd <= '{default: '0};
		end else begin
			a_prev <= enc_a;
			for (int i = 0; i < 2; i++) begin // R5
				if (a_rise[i]) begin
					fwd[i] <= enc_b[i]; // R6 R7
				end
				if (gate_tick) begin
					spd[i] <= speed_of(cnt[i], ppc[i]); // R8 R9 R26
					cnt[i] <= a_rise[i] ? (enc_b[i] ? 16'sh0001 : -16'sh0001) : 16'sh0000;
				end else if (a_rise[i] && mag_of(cnt[i]) < area_pkg::MAX_GATE_COUNT) begin
					cnt[i] <= enc_b[i] ? cnt[i] + 16'sh0001 : cnt[i] - 16'sh0001; // R7 R26
				end
			end
		end
	end

	// Measurable limits, one pulse up to the highest accepted rate
	wire signed [15:0] min_spd = speed_of(16'sh0001, ppc[0]); // R10
	wire signed [15:0] max_spd = speed_of($signed(area_pkg::MAX_GATE_COUNT), ppc[0]); // R10

	// ============================================================
	// Speed comparison
	wire [15:0] mag0 = mag_of(spd[0]);
	wire [15:0] mag1 = mag_of(spd[1]);
	wire signed [15:0] vspd = (mag0 >= mag1) ? spd[0] : spd[1]; // R12
	wire [15:0] vmag = (mag0 >= mag1) ? mag0 : mag1;
	wire [15:0] diff = (mag0 >= mag1) ? mag0 - mag1 : mag1 - mag0;
	wire tol_over = (32'(diff) * 32'h64) > (32'(tol_pct) * 32'(vmag));
	wire moving = vmag > area_pkg::SLOW_CMS;
	wire [15:0] tol_limit = (vmag >= area_pkg::FAST_CMS) ? area_pkg::TOL_FAST_MS
		: area_pkg::TOL_SLOW_MS; // R14
	wire opposite = (spd[0] > 16'sh0000 && spd[1] < 16'sh0000)
		|| (spd[0] < 16'sh0000 && spd[1] > 16'sh0000);
	logic [15:0] tol_ms, dir_ms;
	wire tol_trip = tol_ms > tol_limit; // R13
	wire dir_trip = dir_ms > area_pkg::TOL_DIR_MS; // R15
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tol_ms <= 16'h0000;
			dir_ms <= 16'h0000;
		end else begin
			if (!(tol_over && moving)) begin
				tol_ms <= 16'h0000; // R14
			end else if (ms_tick && !tol_trip) begin
				tol_ms <= tol_ms + 16'h0001; // R13
			end
			if (!(opposite && moving)) begin
				dir_ms <= 16'h0000;
			end else if (ms_tick && !dir_trip) begin
				dir_ms <= dir_ms + 16'h0001; // R15
			end
		end
	end

	// ============================================================
	// Switch pair decode and settling
	wire [2:0] pairs_eff = enc_mode ? 3'h2 : pairs_cfg; // R16
	wire [3:0] pmask = mask_of(pairs_eff);
	wire pair_bad = |((sw_n ~^ sw_i) & pmask); // R22
	wire [3:0] code = ~sw_n & pmask; // R1 R2 R3 R4
	area_pkg::settle_state_type settle_st;
	logic [3:0] pending, sel_code;
	logic [15:0] settle_ms;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_st <= area_pkg::ST_STABLE;
			pending <= 4'h0;
			sel_code <= 4'h0;
			settle_ms <= 16'h0000;
		end else begin
			case (settle_st)
				area_pkg::ST_STABLE: begin
					if (code != sel_code && !pair_bad) begin
						pending <= code;
						settle_ms <= 16'h0000;
						settle_st <= area_pkg::ST_SETTLE;
					end
				end
				area_pkg::ST_SETTLE: begin
					if (code != pending || pair_bad) begin
						pending <= code;
						settle_ms <= 16'h0000; // R23
					end else if (settle_ms >= area_delay) begin
						sel_code <= pending; // R23
						settle_st <= area_pkg::ST_STABLE;
					end else if (ms_tick) begin
						settle_ms <= settle_ms + 16'h0001;
					end
				end
				default: settle_st <= area_pkg::ST_STABLE;
			endcase
		end
	end

	// ============================================================
	// Area selection
	wire [1:0] pat = sel_code[1:0];
	wire [1:0] kind = kinds[2*pat +: 2];
	wire [4:0] static_area = statics[5*pat +: 5];
	logic hit;
	logic [4:0] hit_area;
	logic dup, no_enc;
	always_comb begin
		hit = 1'b0;
		hit_area = 5'h00;
		for (int i = 0; i < RANGES; i++) begin
			// Entries are scanned lowest first; first bound at or above wins
			if (!hit && ranges[i].valid && ranges[i].pattern == pat && vspd <= ranges[i].upper) begin
				hit = 1'b1; // R17 R18
				hit_area = ranges[i].area;
			end
		end
	end
	always_comb begin
		dup = 1'b0;
		for (int i = 0; i < RANGES; i++) begin
			for (int j = i + 1; j < RANGES; j++) begin
				if (ranges[i].valid && ranges[j].valid && ranges[i].pattern == ranges[j].pattern
					&& ranges[i].area == ranges[j].area) begin
					dup = 1'b1; // R19
				end
			end
		end
		no_enc = 1'b1;
		for (int p = 0; p < 4; p++) begin
			if (kinds[2*p +: 2] == area_pkg::PAT_ENCODER) begin
				no_enc = 1'b0; // R16
			end
		end
	end
	wire is_static = enc_mode && kind == area_pkg::PAT_STATIC;
	wire is_enc = enc_mode && kind == area_pkg::PAT_ENCODER;
	wire [5:0] next_area = !enc_mode ? 6'(sel_code) + 6'h01 // R1 R2 R3 R4
		: is_static ? 6'(static_area) + 6'h01 // R20
		: (is_enc && hit) ? 6'(hit_area) + 6'h01 // R18
		: active_area;
	wire win_out = is_static && mon_en[pat] && (vspd < win[pat].lo || vspd > win[pat].hi); // R21
	wire cfg_bad = enc_mode && (kind == area_pkg::PAT_UNUSED || (is_enc && !hit) || dup || no_enc);

	// ============================================================
	// Faults and safety output
	wire stat_wr = wr_fire && paddr == area_pkg::OFF_STATUS;
	wire [4:0] fault_clr = stat_wr ? pwdata[area_pkg::STAT_FAULT_LSB +: 5] : 5'h00;
	wire [4:0] fault_evt = {cfg_bad, win_out, dir_trip, tol_trip, pair_bad};
	// A new event in the clearing cycle survives the clear
	wire [4:0] next_faults = (faults & ~fault_clr) | fault_evt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			faults <= '0;
			safety_output <= 1'b0;
			active_area <= 6'h01;
		end else begin
			faults <= next_faults;
			safety_output <= (next_faults == 5'h00); // R13 R15 R21 R24
			active_area <= next_area;
		end
	end

	// ============================================================
	// APB answer, one wait state on every access
	wire [31:0] rd_mux = (paddr == area_pkg::OFF_CTRL) ? {27'h0, enc_mode, 1'b0, pairs_cfg}
		: (paddr == area_pkg::OFF_ENC) ? {ppc[1], ppc[0]}
		: (paddr == area_pkg::OFF_TOL) ? {area_delay, 9'h000, tol_pct}
		: (paddr == area_pkg::OFF_PAT) ? {mon_en, statics, kinds}
		: (paddr == area_pkg::OFF_STATUS) ? {14'h0, pair_bad, safety_output, 3'h0, faults,
			2'h0, active_area}
		: (paddr == area_pkg::OFF_SPEED) ? {spd[1], spd[0]}
		: (paddr == area_pkg::OFF_LIMITS) ? {max_spd, min_spd}
		: hit_win ? win[win_idx]
		: hit_range ? {8'h00, ranges[range_idx]}
		: 32'h00000000;
	wire addr_ok = paddr[1:0] == 2'h0 && (paddr <= area_pkg::OFF_LIMITS || hit_win || hit_range);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready <= acc && !pready;
			prdata <= (acc && !pready && !pwrite) ? rd_mux : 32'h00000000;
			pslverr <= acc && !pready && !addr_ok;
		end
	end

	// ============================================================
	// Checks
	a_fault_kills_output: assert property (@(posedge pclk) disable iff (!presetn) // R24
		(faults != '0) |-> !safety_output) else $error("Safety output on with a fault");
	a_pair_error_flag: assert property (@(posedge pclk) disable iff (!presetn) // R22
		pair_bad |=> faults.pair && !safety_output) else $error("Pair error not flagged");
	a_dir_trip_off: assert property (@(posedge pclk) disable iff (!presetn) // R15
		$rose(faults.direction) |-> $past(dir_ms) > area_pkg::TOL_DIR_MS && $past(moving))
		else $error("Direction fault too early");
	a_tol_trip_time: assert property (@(posedge pclk) disable iff (!presetn) // R14
		$rose(faults.tolerance) |-> $past(tol_ms) > $past(tol_limit)
		&& $past(vmag) > area_pkg::SLOW_CMS)
		else $error("Tolerance fault before its period");
	a_plain_area: assert property (@(posedge pclk) disable iff (!presetn) // R1
		(!enc_mode && $stable(sel_code)) |=> active_area == 6'($past(sel_code)) + 6'h01)
		else $error("Area does not match code");
	a_settle_delay: assert property (@(posedge pclk) disable iff (!presetn) // R23
		(sel_code != $past(sel_code)) |-> $past(settle_ms) >= $past(area_delay))
		else $error("Area switched before delay");
	a_tol_clamp: assert property (@(posedge pclk) disable iff (!presetn) // R11
		tol_pct <= area_pkg::TOL_MAX_PCT) else $error("Tolerance above eighty percent");
	a_phase_dir: assert property (@(posedge pclk) disable iff (!presetn) // R6
		a_rise[0] |=> fwd[0] == $past(enc_b[0])) else $error("Direction not sampled");
	a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
		(acc && !pready) |=> pready ##1 !pready) else $error("APB answer timing wrong");
	a_window_off: assert property (@(posedge pclk) disable iff (!presetn) // R21
		win_out |=> !safety_output [*2]) else $error("Window breach kept output on");
endmodule // area_select_speed_monitor
`default_nettype wire

// ==== quad_encoder_model.sv ====
// Behavioural incremental encoder driving one quadrature phase pair
`timescale 1ns/1ps
`default_nettype none
module quad_encoder_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Motion control: cycles per quarter step, zero stands still
	input wire logic [15:0] quarter,
	input wire logic backward,
	// Phase outputs
	output logic phase_a,
	output logic phase_b
);
	logic [15:0] count;
	logic [1:0] step;
	// ============================================================
	// Step sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= 16'h0000;
			step <= 2'h0;
		end else if (quarter == 16'h0000) begin
			count <= 16'h0000;
		end else if (count >= quarter - 16'h0001) begin
			count <= 16'h0000;
			// Reversing the sequence flips which phase leads
			step <= backward ? step - 2'h1 : step + 2'h1;
		end else begin
			count <= count + 16'h0001;
		end
	end
	// Forward: B rises a quarter before A, so B is high at each A rise
	assign phase_a = step[1];
	assign phase_b = step[1] ^ step[0];
endmodule // quad_encoder_model
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the area select and speed monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
	$display("mismatch %s expected %h seen %h", nm, exp, got); end end
module testbench;
	localparam int CPM = 10;
	localparam int CEIL = 80000;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic pready;
	logic [31:0] prdata;
	logic pslverr;
	logic [3:0] sel_normal = 4'hF;
	logic [3:0] sel_inverse = 4'h0;
	wire logic [1:0] enc_phase_a;
	wire logic [1:0] enc_phase_b;
	logic safety_output;
	logic [5:0] active_area;
	logic [15:0] quarter1 = 16'h0000;
	logic [15:0] quarter2 = 16'h0000;
	logic [1:0] backward = 2'b00;
	logic last_err;
	int bad_count = 0;
	int checks_done = 0;
	int cycles = 0;
	// ============================================================
	// Design and far side
	area_select_speed_monitor #(.CYC_PER_MS(CPM), .PAIRS(4), .RANGES(32)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.sel_normal(sel_normal), .sel_inverse(sel_inverse), .enc_phase_a(enc_phase_a),
		.enc_phase_b(enc_phase_b), .safety_output(safety_output), .active_area(active_area));
	// Two separate encoders so disagreement can be staged
	quad_encoder_model enc1_model (.pclk(pclk), .presetn(presetn), .quarter(quarter1),
		.backward(backward[0]), .phase_a(enc_phase_a[0]), .phase_b(enc_phase_b[0]));
	quad_encoder_model enc2_model (.pclk(pclk), .presetn(presetn), .quarter(quarter2),
		.backward(backward[1]), .phase_a(enc_phase_a[1]), .phase_b(enc_phase_b[1]));
	always #4 pclk = ~pclk;
	// ============================================================
	// Closing and hang guard
	task wrap_up;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	always @(posedge pclk) begin
		cycles++;
		if (cycles == CEIL) begin
			bad_count++;
			wrap_up();
		end
	end
	// ============================================================
	// Bus and wait helpers
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// Only the bench timeout ends this wait
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask
	task rd(input logic [11:0] a, output logic [31:0] q);
		apb(1'b0, a, 32'h00000000, q);
	endtask
	task set_sel(input logic [3:0] code);
		sel_normal <= ~code;
		sel_inverse <= code;
	endtask
	task wait_area(input logic [5:0] exp, input int lim);
		int n;
		n = 0;
		while (active_area !== exp && n < lim) begin
			@(posedge pclk);
			n++;
		end
	endtask
	task wait_safe(input logic exp, input int lim);
		int n;
		n = 0;
		while (safety_output !== exp && n < lim) begin
			@(posedge pclk);
			n++;
		end
	endtask
	// ============================================================
	// Scenarios
	task t_reset;
		logic [31:0] q;
		rd(area_pkg::OFF_CTRL, q); `CHK("ctrl", 32'h00000004, q)
		rd(area_pkg::OFF_ENC, q); `CHK("enc", 32'h00400040, q)
		rd(area_pkg::OFF_TOL, q); `CHK("tol", 32'h001E000A, q)
		rd(area_pkg::OFF_PAT, q); `CHK("pat", 32'h00000002, q)
		rd(area_pkg::OFF_LIMITS, q); `CHK("max speed", 16'h061A, q[31:16])
		rd(12'h020, q); `CHK("unmapped err", 1'b1, last_err)
		`CHK("unmapped data", 32'h00000000, q)
		// Short area delay keeps the decode sweep quick
		wr(area_pkg::OFF_TOL, 32'h00020064);
		rd(area_pkg::OFF_TOL, q); `CHK("tol clamp", 32'h00020050, q)
		`CHK("area reset", 6'h01, active_area)
		// Synchronisers start with both lines equal, so release latches a pair fault
		rd(area_pkg::OFF_STATUS, q); `CHK("start pair", 1'b1, q[8])
		`CHK("safe start", 1'b0, safety_output)
		wr(area_pkg::OFF_STATUS, 32'h00001F00);
		wait_safe(1'b1, 20);
		`CHK("safe reset", 1'b1, safety_output)
	endtask
	task t_decode;
		int pairs_tab [9] = '{4, 4, 3, 3, 2, 2, 1, 1, 4};
		logic [3:0] code_tab [9] = '{4'hF, 4'h5, 4'hF, 4'h2, 4'hD, 4'h3, 4'h2, 4'h7, 4'h0};
		logic [5:0] exp;
		for (int i = 0; i < 9; i++) begin
			wr(area_pkg::OFF_CTRL, 32'(pairs_tab[i]));
			set_sel(code_tab[i]);
			exp = 6'(code_tab[i] & 4'((1 << pairs_tab[i]) - 1)) + 6'h01;
			wait_area(exp, 100);
			`CHK("area decode", exp, active_area)
		end
		set_sel(4'hA);
		repeat (10) @(posedge pclk);
		`CHK("area before delay", 6'h01, active_area)
		wait_area(6'h0B, 100);
		`CHK("area after delay", 6'h0B, active_area)
	endtask
	task t_pair;
		logic [31:0] q;
		sel_normal <= 4'hC;
		sel_inverse <= 4'h1;
		wait_safe(1'b0, 100);
		`CHK("safe pair", 1'b0, safety_output)
		rd(area_pkg::OFF_STATUS, q); `CHK("live pair", 1'b1, q[17])
		`CHK("pair fault", 1'b1, q[8])
		repeat (60) @(posedge pclk);
		`CHK("area held", 6'h0B, active_area)
		set_sel(4'hA);
		repeat (10) @(posedge pclk);
		wr(area_pkg::OFF_STATUS, 32'h00000100);
		rd(area_pkg::OFF_STATUS, q); `CHK("pair cleared", 1'b0, q[8])
		wait_safe(1'b1, 20);
		`CHK("safe back", 1'b1, safety_output)
	endtask
	task t_speed;
		logic [31:0] q;
		wr(area_pkg::OFF_ENC, 32'h00010001);
		// Two A rises per 100 ms gate at one pulse per cm gives 20 cm/s
		quarter1 <= 16'd125;
		quarter2 <= 16'd125;
		repeat (3500) @(posedge pclk);
		rd(area_pkg::OFF_SPEED, q); `CHK("speed fwd", 32'h00140014, q)
		backward <= 2'b11;
		repeat (3500) @(posedge pclk);
		rd(area_pkg::OFF_SPEED, q); `CHK("speed back", 32'hFFECFFEC, q)
		`CHK("safe same dir", 1'b1, safety_output)
	endtask
	task t_dir;
		logic [31:0] q;
		backward <= 2'b01;
		repeat (2500) @(posedge pclk);
		`CHK("safe dir early", 1'b1, safety_output)
		wait_safe(1'b0, 6000);
		`CHK("safe dir trip", 1'b0, safety_output)
		rd(area_pkg::OFF_STATUS, q); `CHK("dir fault", 1'b1, q[10])
		quarter1 <= 16'h0000;
		quarter2 <= 16'h0000;
		repeat (3500) @(posedge pclk);
		wr(area_pkg::OFF_STATUS, 32'h00001F00);
		wait_safe(1'b1, 50);
		`CHK("safe dir clear", 1'b1, safety_output)
	endtask
	task t_encmode;
		logic [31:0] q;
		// Each area used once within the pattern
		wr(12'h080, 32'h0082000F);
		wr(12'h084, 32'h00837FFF);
		wr(12'h044, 32'h000A0000);
		wr(area_pkg::OFF_PAT, 32'h2000C006);
		set_sel(4'h0);
		wr(area_pkg::OFF_CTRL, 32'h00000012);
		wait_area(6'h03, 200);
		`CHK("area slow range", 6'h03, active_area)
		// Old code points at an unused pattern until the new one settles
		wr(area_pkg::OFF_STATUS, 32'h00001F00);
		backward <= 2'b00;
		quarter1 <= 16'd125;
		quarter2 <= 16'd250;
		wait_area(6'h04, 3000);
		`CHK("area fast range", 6'h04, active_area)
		`CHK("safe enc pattern", 1'b1, safety_output)
		set_sel(4'h1);
		wait_area(6'h07, 200);
		`CHK("area static", 6'h07, active_area)
		wait_safe(1'b0, 200);
		`CHK("safe window", 1'b0, safety_output)
		rd(area_pkg::OFF_STATUS, q); `CHK("window fault", 1'b1, q[11])
		set_sel(4'h2);
		repeat (60) @(posedge pclk);
		rd(area_pkg::OFF_STATUS, q); `CHK("unused fault", 1'b1, q[12])
		`CHK("area unused held", 6'h07, active_area)
	endtask
	// ============================================================
	// Main sequence
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_decode();
		t_pair();
		t_speed();
		t_dir();
		t_encmode();
		wrap_up();
	end
endmodule // testbench
`undef CHK
`default_nettype wire
